// ===== bench/tlmc_host.sv
`timescale 1ns/1ps
module tlmc_host (
  input  wire         sys_clk,
  input  wire  [7:0]  reg_rdata,
  output logic [15:0] reg_addr,
  output logic [7:0]  reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic        cmd_exec,
  output logic        cmd_clear
);
  // Idle bus at time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, cmd_exec, cmd_clear} = '0;
  end
  // Released strobes drop; address, data and clear lines flip so a stale value never passes for a live one
  task automatic drop();
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cmd_exec  = 1'b0;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
    cmd_clear = ~cmd_clear;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    drop();
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    d = reg_rdata;
    drop();
  endtask
  // Clear command goes out as the very next access after enabling it
  task automatic cmd(input logic clr);
    @(negedge sys_clk);
    cmd_clear = clr;
    cmd_exec  = 1'b1;
    @(negedge sys_clk);
    drop();
  endtask
endmodule

// ===== bench/tlmc_props.sv
`timescale 1ns/1ps
module tlmc_props #(
  parameter [25:0] WAKE_CYC  = 26'd4,
  parameter [25:0] TOTAL_CYC = 26'd20
) (
  input wire              sys_clk,
  input wire              sys_rst,
  input wire [15:0]       reg_addr,
  input wire [7:0]        reg_wdata,
  input wire              reg_wr,
  input wire              reg_rd,
  input wire [7:0]        reg_rdata,
  input wire              cmd_exec,
  input wire              cmd_clear,
  input wire              cmd_convert,
  input wire              sec_tick,
  input wire              sec_rollover,
  input wire              rtc_alarm,
  input wire              conv_done,
  input wire signed [9:0] conv_raw,
  input wire              conv_start,
  input wire              osc_run,
  input wire              log_we,
  input wire [15:0]       log_addr,
  input wire [7:0]        log_data,
  input wire              hist_we,
  input wire [5:0]        hist_bin,
  input wire              clear_pages,
  input wire              search_hit
);
  reg clren_reg;
  reg busy_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // Shadow of clear enable and converter activity, seen from the ports
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clren_reg <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 16'h020e) clren_reg <= reg_wdata[6];
      else if (cmd_exec) clren_reg <= 1'b0;
      busy_reg <= conv_start | (busy_reg & ~conv_done);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_ctrl_gap;
    reg_rd && reg_addr == 16'h020e |=> reg_rdata[5] == 1'b0;
  endproperty
  a_ctrl_gap:
    assert property (p_ctrl_gap) else $error("control bit 5 read as one");
  property p_stat_gap;
    reg_rd && reg_addr == 16'h0214 |=> reg_rdata[3] == 1'b0;
  endproperty
  a_stat_gap:
    assert property (p_stat_gap) else $error("status bit 3 read as one");
  property p_osc;
    reg_wr && reg_addr == 16'h020e |-> ##2 osc_run == !$past(reg_wdata[7], 2);
  endproperty
  a_osc:
    assert property (p_osc) else $error("oscillator run does not follow control");
  property p_clear;
    1'b1 |=> clear_pages == $past(cmd_exec & cmd_clear & clren_reg);
  endproperty
  a_clear:
    assert property (p_clear) else $error("clear pulse wrong");
  property p_busy;
    reg_rd && reg_addr == 16'h0214 && (conv_start | busy_reg) && !conv_done |=> !reg_rdata[7];
  endproperty
  a_busy:
    assert property (p_busy) else $error("idle bit high during conversion");
  property p_code;
    log_we |-> $past(conv_done) && log_data == (($past(conv_raw) < 10'sd0) ? 8'h00 :
      ($past(conv_raw) > 10'sd250) ? 8'hfa : $past(conv_raw[7:0]));
  endproperty
  a_code:
    assert property (p_code) else $error("logged code wrong");
  property p_addr;
    log_we |-> log_addr[15:11] == 5'h02;
  endproperty
  a_addr:
    assert property (p_addr) else $error("log address outside log area");
  property p_hist;
    hist_we && log_we |-> hist_bin == log_data[7:2];
  endproperty
  a_hist:
    assert property (p_hist) else $error("histogram bin wrong");
  property p_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_pulse:
    assert property (p_pulse) else $error("conversion start longer than a cycle");
endmodule
bind tlmc_top tlmc_props #(.WAKE_CYC(WAKE_CYC), .TOTAL_CYC(TOTAL_CYC)) i_tlmc_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_exec(cmd_exec),
  .cmd_clear(cmd_clear), .cmd_convert(cmd_convert), .sec_tick(sec_tick),
  .sec_rollover(sec_rollover), .rtc_alarm(rtc_alarm), .conv_done(conv_done),
  .conv_raw(conv_raw), .conv_start(conv_start), .osc_run(osc_run), .log_we(log_we),
  .log_addr(log_addr), .log_data(log_data), .hist_we(hist_we), .hist_bin(hist_bin),
  .clear_pages(clear_pages), .search_hit(search_hit));

// ===== bench/tlmc_tb_top.sv
`timescale 1ns/1ps
module tlmc_tb_top;
  logic              sys_clk, sys_rst, cmd_convert, sec_tick, sec_rollover, rtc_alarm, conv_done;
  logic signed [9:0] conv_raw;
  wire  [15:0]       reg_addr, log_addr;
  wire  [7:0]        reg_wdata, reg_rdata, log_data;
  wire  [5:0]        hist_bin;
  wire               reg_wr, reg_rd, cmd_exec, cmd_clear, conv_start, osc_run, log_we, hist_we;
  wire               clear_pages, search_hit;
  integer            n_errors, samples_checked, seed, i, n_log, raw, cw, lq;
  int                exp_q[$];
  int                tbl[10] = '{-1, 0, 1, 249, 250, 251, 300, 0, 0, 0};
  logic [7:0]        rv;
  logic [31:0]       rnd;
  tlmc_top #(.WAKE_CYC(26'd4), .TOTAL_CYC(26'd20)) i_tlmc_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_exec(cmd_exec), .cmd_clear(cmd_clear), .cmd_convert(cmd_convert), .sec_tick(sec_tick),
    .sec_rollover(sec_rollover), .rtc_alarm(rtc_alarm), .conv_done(conv_done), .conv_raw(conv_raw),
    .conv_start(conv_start), .osc_run(osc_run), .log_we(log_we), .log_addr(log_addr), .log_data(log_data),
    .hist_we(hist_we), .hist_bin(hist_bin), .clear_pages(clear_pages), .search_hit(search_hit));
  tlmc_host i_tlmc_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .cmd_exec(cmd_exec), .cmd_clear(cmd_clear));
  ////////////////////////////////////////////////////////////////////////
  always #10 sys_clk = ~sys_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] code_of(input int r);
    code_of = r < 0 ? 8'h00 : r > 250 ? 8'hfa : r[7:0];
  endfunction
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Wait for the converter kick, peek at status, then hand back a result
  task automatic run_conv(input int r, input logic [3:0] hi);
    for (cw = 0; cw < 100 && conv_start !== 1'b1; cw++) @(negedge sys_clk);
    check(cw < 100, 1'b1);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv[7:4], hi);
    @(negedge sys_clk);
    conv_raw  = r;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    conv_raw  = ~conv_raw;
    repeat (2) @(negedge sys_clk);
  endtask
  // Every logged sample against the model queue
  // Looked at on the falling edge, where the registered outputs have settled
  always @(negedge sys_clk) begin
    if (log_we) begin
      lq = exp_q.pop_front();
      check(log_addr, 16'h1000 + n_log);
      check(log_data, lq[7:0]);
      check(hist_bin, lq[7:2]);
      n_log++;
    end
  end
  // Hang guard
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_clk, cmd_convert, sec_tick, sec_rollover, rtc_alarm, conv_done, conv_raw} = '0;
    {n_errors, samples_checked, n_log} = '0;
    seed    = 73;
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'h80);
    i_tlmc_host.rd(16'h0300, rv);
    check(rv, 8'h00);
    i_tlmc_host.wr(16'h020e, 8'hff);
    i_tlmc_host.rd(16'h020e, rv);
    check(rv, 8'hdf);
    check(osc_run, 1'b0);
    i_tlmc_host.wr(16'h020e, 8'h00);
    i_tlmc_host.wr(16'h0214, 8'hff);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'h80);
    for (i = 0; i < 2; i++) begin
      rnd = $random(seed);
      i_tlmc_host.wr(16'h020b + i, rnd[7:0]);
      i_tlmc_host.rd(16'h020b + i, rv);
      check(rv, rnd[7:0]);
    end
    i_tlmc_host.wr(16'h020b, 8'h50);
    i_tlmc_host.wr(16'h020c, 8'hb0);
    for (i = 0; i < 10; i++) begin
      rnd = $random(seed);
      raw = i < 7 ? tbl[i] : $signed(rnd[9:0]);
      @(negedge sys_clk) cmd_convert = 1'b1;
      @(negedge sys_clk) cmd_convert = 1'b0;
      run_conv(raw, 4'h0);
      i_tlmc_host.rd(16'h0211, rv);
      check(rv, code_of(raw));
    end
    i_tlmc_host.wr(16'h020e, 8'h40);
    i_tlmc_host.cmd(1'b1);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'hc0);
    i_tlmc_host.rd(16'h020e, rv);
    check(rv, 8'h00);
    i_tlmc_host.wr(16'h020d, 8'h01);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'hc0);
    @(negedge sys_clk) sec_tick = 1'b1;
    @(negedge sys_clk) sec_tick = 1'b0;
    i_tlmc_host.wr(16'h020d, 8'h01);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'ha0);
    for (i = 0; i < 3; i++) begin
      raw = i == 0 ? 40 : i == 1 ? 120 : 300;
      exp_q.push_back(code_of(raw));
      @(negedge sys_clk) sec_rollover = 1'b1;
      @(negedge sys_clk) sec_rollover = 1'b0;
      run_conv(raw, 4'h3);
    end
    check(n_log, 3);
    @(negedge sys_clk) rtc_alarm = 1'b1;
    @(negedge sys_clk) rtc_alarm = 1'b0;
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'ha7);
    i_tlmc_host.wr(16'h0214, 8'hfb);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'ha3);
    i_tlmc_host.rd(16'h021a, rv);
    check(rv, 8'h03);
    i_tlmc_host.wr(16'h020e, 8'h00);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'h83);
    // Search enables against the flags left by the mission
    i_tlmc_host.wr(16'h020e, 8'h01);
    @(negedge sys_clk);
    check(search_hit, 1'b1);
    i_tlmc_host.wr(16'h020e, 8'h04);
    @(negedge sys_clk);
    check(search_hit, 1'b0);
    // Second mission with a one-minute start delay
    i_tlmc_host.wr(16'h020e, 8'h40);
    i_tlmc_host.cmd(1'b1);
    i_tlmc_host.wr(16'h0212, 8'h01);
    i_tlmc_host.wr(16'h020d, 8'h01);
    n_log = 0;
    @(negedge sys_clk) sec_rollover = 1'b1;
    @(negedge sys_clk) sec_rollover = 1'b0;
    i_tlmc_host.rd(16'h0212, rv);
    check(rv, 8'h00);
    i_tlmc_host.rd(16'h0214, rv);
    check(rv, 8'ha3);
    @(negedge sys_clk) cmd_convert = 1'b1;
    @(negedge sys_clk) cmd_convert = 1'b0;
    check(conv_start, 1'b0);
    exp_q.push_back(code_of(96));
    @(negedge sys_clk) sec_rollover = 1'b1;
    @(negedge sys_clk) sec_rollover = 1'b0;
    run_conv(96, 4'h3);
    check(n_log, 1);
    i_tlmc_host.rd(16'h021a, rv);
    check(rv, 8'h01);
    print_verdict();
  end
endmodule

// ===== hw/tlmc_regs.vh
// Notes on behaviour
// - Temperature code is one byte, limited to 00h..FAh; 01h..F9h are in range.
// - Below-range results record 00h, above-range results record FAh.
// - Half-degree steps: code equals twice Celsius plus 80.
// - Conversion idle bit reads 0 from conversion start until result latched.
// - Mission samples are spaced by sample interval minutes, 1 to 255.
// - Nonzero interval write starts mission if memory cleared and enable low.
// - Control write during a mission ends it and updates the contents.
// - Control bit 5 always reads 0; status bit 3 has no function.
// - Oscillator disable 0 runs oscillator; 1 stops it, low-power retention.
// - Mission start refused until clock advanced a second since oscillator start.
// - Clear enable then clear command next; enable drops on next command.
// - Clear command zeroes mission data, interval, delay; sets memory cleared.
// - Memory cleared drops at mission start; no start without clearing.
// - Wrap on: log restarts at base; off: log stops, mission continues.
// - Search enables answer conditional search on low, high, timer events.
// - Logging waits 16-bit start delay minutes, low byte 212h, high 213h.
// - Status: mission and alarm flags write 0 only; others read-only.
// - Mission active until write attempt to 200h..213h or written 0.
// - Samples at seconds rollover; sample bit leads 250 ms; total under 875 ms.
// - Reads stay allowed during a sample; host treats data as possibly stale.
// - Low/high flags set when sample at or beyond thresholds; host clears.
// - Timer flag set by clock alarm, cleared by writing 0.
// - Every clock alarm match sets the timer alarm flag.
// - First sample goes to log address 1000h, then consecutive addresses.
`ifndef TLMC_REGS_VH
`define TLMC_REGS_VH
`define TLMC_A_LOW      16'h020b
`define TLMC_A_HIGH     16'h020c
`define TLMC_A_RATE     16'h020d
`define TLMC_A_CTRL     16'h020e
`define TLMC_A_READOUT  16'h0211
`define TLMC_A_DLY_LO   16'h0212
`define TLMC_A_DLY_HI   16'h0213
`define TLMC_A_STAT     16'h0214
`define TLMC_A_CNT_LO   16'h021a
`define TLMC_A_CNT_MID  16'h021b
`define TLMC_A_CNT_HI   16'h021c
`define TLMC_A_LOCK_LO  16'h0200
`define TLMC_A_LOCK_HI  16'h0213
`define TLMC_LOG_BASE   16'h1000
`define TLMC_CODE_MIN   8'h00
`define TLMC_CODE_MAX   8'hfa
`define TLMC_CTRL_WMASK 8'hdf
`define TLMC_B_OSC      7
`define TLMC_B_CLREN    6
`define TLMC_B_EMN      4
`define TLMC_B_WRAP     3
`define TLMC_B_LOW      2
`define TLMC_B_HIGH     1
`define TLMC_B_TMR      0
`define TLMC_B_MIP      5
`define TLMC_CTRL_RST   8'h00
`define TLMC_CLK_HZ     50000000
`define TLMC_WAKE_MS    250
`define TLMC_TOTAL_MS   875
`define TLMC_WAKE_CYC   26'd12500000
`define TLMC_TOTAL_CYC  26'd43750000
`define TLMC_LOG_LAST   11'h7ff
`endif

// ===== hw/tlmc_top.v
`timescale 1ns/1ps
`include "tlmc_regs.vh"

module tlmc_top #(
  // Wake lead before the conversion, rounded down
  parameter [25:0] WAKE_CYC = `TLMC_WAKE_CYC,
  // Wake plus conversion limit, rounded down
  parameter [25:0] TOTAL_CYC = `TLMC_TOTAL_CYC
) (
  sys_clk,
  sys_rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  cmd_exec,
  cmd_clear,
  cmd_convert,
  sec_tick,
  sec_rollover,
  rtc_alarm,
  conv_done,
  conv_raw,
  conv_start,
  osc_run,
  log_we,
  log_addr,
  log_data,
  hist_we,
  hist_bin,
  clear_pages,
  search_hit
);
  input  wire        sys_clk;
  input  wire        sys_rst;
  input  wire [15:0] reg_addr;
  input  wire [7:0]  reg_wdata;
  input  wire        reg_wr;
  input  wire        reg_rd;
  output reg  [7:0]  reg_rdata;
  input  wire        cmd_exec;
  input  wire        cmd_clear;
  input  wire        cmd_convert;
  input  wire        sec_tick;
  input  wire        sec_rollover;
  input  wire        rtc_alarm;
  input  wire        conv_done;
  input  wire signed [9:0] conv_raw;
  output reg         conv_start;
  output reg         osc_run;
  output reg         log_we;
  output reg  [15:0] log_addr;
  output reg  [7:0]  log_data;
  output reg         hist_we;
  output reg  [5:0]  hist_bin;
  output reg         clear_pages;
  output reg         search_hit;

  ////////////////////////////////////////////////////////////
  // Sample sequencer states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAKE = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  // Write attempts here end a running mission
  function lock_range;
    input [15:0] a;
    begin
      lock_range = (a >= `TLMC_A_LOCK_LO) && (a <= `TLMC_A_LOCK_HI);
    end
  endfunction

  // Clamp raw reading into the byte code range
  function [7:0] clamp_code;
    input signed [9:0] r;
    begin
      if (r < $signed({2'b00, `TLMC_CODE_MIN}))
        clamp_code = `TLMC_CODE_MIN;
      else if (r > $signed({2'b00, `TLMC_CODE_MAX}))
        clamp_code = `TLMC_CODE_MAX;
      else
        clamp_code = r[7:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////
  reg  [7:0]  low_reg;
  reg  [7:0]  high_reg;
  reg  [7:0]  rate_reg;
  reg  [7:0]  ctrl_reg;
  reg  [15:0] delay_reg;
  reg  [7:0]  readout_reg;
  reg         idle_reg;
  reg         memory_cleared_reg;
  reg         mip_reg;
  reg         sip_reg;
  reg         tlf_reg;
  reg         thf_reg;
  reg         taf_reg;
  reg         osc_ok_reg;
  reg         logging_reg;
  reg  [7:0]  ivl_reg;
  reg  [23:0] count_reg;
  reg  [10:0] ptr_reg;
  reg         full_reg;
  reg  [2:0]  state_reg;
  reg  [25:0] timer_reg;
  reg         msn_conv_reg;

  // Low threshold compare, declared after the register it reads
  function readout_next_le_low;
    input [7:0] c;
    begin
      readout_next_le_low = (c <= low_reg);
    end
  endfunction

  wire [7:0] stat_rd = {idle_reg, memory_cleared_reg, mip_reg, sip_reg,
                        1'b0, tlf_reg, thf_reg, taf_reg};
  // Raw reading clamped once, shared by readout, log and flags
  wire [7:0] code = clamp_code(conv_raw);

  // Decoded write strobes
  wire wr_rate = reg_wr && (reg_addr == `TLMC_A_RATE);
  wire wr_ctrl = reg_wr && (reg_addr == `TLMC_A_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `TLMC_A_STAT);
  wire wr_lock = reg_wr && lock_range(reg_addr);

  // Start only from a cleared, enabled, clock-proven state
  wire start = wr_rate && (reg_wdata != 8'h00) && memory_cleared_reg
               && !ctrl_reg[`TLMC_B_EMN] && osc_ok_reg
               && !mip_reg;
  wire do_clear = cmd_exec && cmd_clear
                  && ctrl_reg[`TLMC_B_CLREN];
  wire mip_end = (mip_reg && wr_lock)
                 || (wr_stat && !reg_wdata[`TLMC_B_MIP]);
  // A rollover during a running sample is skipped; the interval still counts
  // A minute boundary that produces a mission sample
  wire tick_sample = sec_rollover && mip_reg && !mip_end
                     && state_reg == ST_IDLE && (logging_reg
                     ? (ivl_reg >= rate_reg)
                     : (delay_reg == 16'h0000));
  // Result handshake, mission or forced
  wire latch = (state_reg == ST_CONV) && conv_done;
  wire msn_latch = latch && msn_conv_reg;

  ////////////////////////////////////////////////////////////
  // Configuration registers; writes always land, except rate and delay writes in a clear cycle
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_reg   <= 8'h00;
      high_reg  <= 8'h00;
      rate_reg  <= 8'h00;
      ctrl_reg  <= `TLMC_CTRL_RST;
      delay_reg <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `TLMC_A_LOW)
        low_reg <= reg_wdata;
      if (reg_wr && reg_addr == `TLMC_A_HIGH)
        high_reg <= reg_wdata;
      if (do_clear)
        rate_reg <= 8'h00;
      else if (wr_rate)
        rate_reg <= reg_wdata;
      // A control write beats the enable drop of a command
      if (wr_ctrl)
        ctrl_reg <= reg_wdata & `TLMC_CTRL_WMASK;
      else if (cmd_exec)
        ctrl_reg[`TLMC_B_CLREN] <= 1'b0;
      // Delay doubles as the countdown, as a read shows
      if (do_clear)
        delay_reg <= 16'h0000;
      else if (reg_wr && reg_addr == `TLMC_A_DLY_LO)
        delay_reg[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == `TLMC_A_DLY_HI)
        delay_reg[15:8] <= reg_wdata;
      else if (sec_rollover && mip_reg && !logging_reg
               && delay_reg != 16'h0000)
        delay_reg <= delay_reg - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////
  // Oscillator proof: one second seen while running
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_ok_reg <= 1'b0;
      osc_run    <= 1'b0;
    end else begin
      osc_run <= !ctrl_reg[`TLMC_B_OSC];
      // Stopping the oscillator withdraws the proof at once
      if (ctrl_reg[`TLMC_B_OSC])
        osc_ok_reg <= 1'b0;
      else if (sec_tick)
        osc_ok_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Mission state and status flags; hardware set beats clear
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memory_cleared_reg  <= 1'b0;
      mip_reg     <= 1'b0;
      tlf_reg     <= 1'b0;
      thf_reg     <= 1'b0;
      taf_reg     <= 1'b0;
      logging_reg <= 1'b0;
      ivl_reg     <= 8'h00;
    end else begin
      // A clear in the same cycle as a start wins
      if (do_clear)
        memory_cleared_reg <= 1'b1;
      else if (start)
        memory_cleared_reg <= 1'b0;
      if (start)
        mip_reg <= 1'b1;
      else if (mip_end)
        mip_reg <= 1'b0;
      // Minutes since the last sample; saturates rather than wraps
      if (start) begin
        logging_reg <= 1'b0;
        ivl_reg     <= 8'h00;
      end else if (tick_sample) begin
        logging_reg <= 1'b1;
        ivl_reg     <= 8'h01;
      end else if (sec_rollover && logging_reg && ivl_reg != 8'hff)
        ivl_reg <= ivl_reg + 8'h01;
      // Threshold flags only from mission samples
      if (msn_latch && readout_next_le_low(code))
        tlf_reg <= 1'b1;
      else if (wr_stat && !reg_wdata[`TLMC_B_LOW])
        tlf_reg <= 1'b0;
      if (msn_latch && code >= high_reg)
        thf_reg <= 1'b1;
      else if (wr_stat && !reg_wdata[`TLMC_B_HIGH])
        thf_reg <= 1'b0;
      // Alarm match sets the flag whatever the mask setting
      if (rtc_alarm)
        taf_reg <= 1'b1;
      else if (wr_stat && !reg_wdata[`TLMC_B_TMR])
        taf_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Sample sequencer: wake lead for mission samples, then bounded conversion
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      timer_reg    <= 26'd0;
      sip_reg      <= 1'b0;
      idle_reg     <= 1'b1;
      conv_start   <= 1'b0;
      msn_conv_reg <= 1'b0;
      readout_reg  <= 8'h00;
    end else begin
      conv_start <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          timer_reg <= 26'd0;
          if (tick_sample) begin
            sip_reg   <= 1'b1;
            state_reg <= ST_WAKE;
          end else if (cmd_convert && !mip_reg) begin
            idle_reg     <= 1'b0;
            conv_start   <= 1'b1;
            msn_conv_reg <= 1'b0;
            state_reg    <= ST_CONV;
          end
        end
        ST_WAKE: begin
          timer_reg <= timer_reg + 26'd1;
          if (timer_reg + 26'd1 >= WAKE_CYC) begin
            idle_reg     <= 1'b0;
            conv_start   <= 1'b1;
            msn_conv_reg <= 1'b1;
            state_reg    <= ST_CONV;
          end
        end
        ST_CONV: begin
          timer_reg <= timer_reg + 26'd1;
          // Timeout keeps the 875 ms bound if no result comes
          // An abort leaves the old readout in place
          if (conv_done || timer_reg + 26'd1 >= TOTAL_CYC) begin
            if (conv_done)
              readout_reg <= code;
            idle_reg  <= 1'b1;
            sip_reg   <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sip_reg   <= 1'b0;
          idle_reg  <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Log pointer, histogram and sample counter
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg   <= 11'd0;
      full_reg  <= 1'b0;
      count_reg <= 24'd0;
      log_we    <= 1'b0;
      log_addr  <= `TLMC_LOG_BASE;
      log_data  <= 8'h00;
      hist_we   <= 1'b0;
      hist_bin  <= 6'd0;
    end else begin
      log_we  <= 1'b0;
      hist_we <= 1'b0;
      // A fresh mission logs from the base again
      if (do_clear || start) begin
        ptr_reg  <= 11'd0;
        full_reg <= 1'b0;
      end
      if (do_clear)
        count_reg <= 24'd0;
      else if (msn_latch) begin
        count_reg <= count_reg + 24'd1;
        hist_we   <= 1'b1;
        hist_bin  <= code[7:2];
        // Wrap off: log stops, histogram keeps going
        if (!full_reg || ctrl_reg[`TLMC_B_WRAP]) begin
          log_we   <= 1'b1;
          log_addr <= `TLMC_LOG_BASE + {5'd0, ptr_reg};
          log_data <= code;
          ptr_reg  <= ptr_reg + 11'd1;
          // Last slot written: wrap off freezes the log here
          if (ptr_reg == `TLMC_LOG_LAST)
            full_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Read port and search flag; reads never stall on samples
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata   <= 8'h00;
      clear_pages <= 1'b0;
      search_hit  <= 1'b0;
    end else begin
      clear_pages <= do_clear;
      // Flags outlive the mission, so a search still finds them
      search_hit  <= (ctrl_reg[`TLMC_B_LOW] && tlf_reg)
                     || (ctrl_reg[`TLMC_B_HIGH] && thf_reg)
                     || (ctrl_reg[`TLMC_B_TMR] && taf_reg);
      if (reg_rd) begin
        case (reg_addr)
          `TLMC_A_LOW:     reg_rdata <= low_reg;
          `TLMC_A_HIGH:    reg_rdata <= high_reg;
          `TLMC_A_RATE:    reg_rdata <= rate_reg;
          `TLMC_A_CTRL:    reg_rdata <= ctrl_reg;
          `TLMC_A_READOUT: reg_rdata <= readout_reg;
          `TLMC_A_DLY_LO:  reg_rdata <= delay_reg[7:0];
          `TLMC_A_DLY_HI:  reg_rdata <= delay_reg[15:8];
          `TLMC_A_STAT:    reg_rdata <= stat_rd;
          `TLMC_A_CNT_LO:  reg_rdata <= count_reg[7:0];
          `TLMC_A_CNT_MID: reg_rdata <= count_reg[15:8];
          `TLMC_A_CNT_HI:  reg_rdata <= count_reg[23:16];
          // Unmapped addresses read as zero
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
